// file: rtl/fmt_defines.svh
// Register map, field positions, reset values and timing counts of the field memory timing block
`ifndef FMT_DEFINES_SVH
`define FMT_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define FMT_OFF_CTRL    8'h00
`define FMT_OFF_CLAMP   8'h04
`define FMT_OFF_HWIN1   8'h08
`define FMT_OFF_VSAMP   8'h0c
`define FMT_OFF_VWIN1   8'h10
`define FMT_OFF_ALINE   8'h14
`define FMT_OFF_STEP01  8'h18
`define FMT_OFF_STEP23  8'h1c
`define FMT_OFF_BLANK   8'h20
`define FMT_OFF_HWIN2   8'h24
`define FMT_OFF_VWIN2   8'h28
`define FMT_OFF_DLINE   8'h2c
`define FMT_OFF_STATUS  8'h30
`define FMT_NUM_CFG     12

// ****************************************
// Control register field positions
// ****************************************
`define FMT_CTRL_FSEL   0
`define FMT_CTRL_DBL    2
`define FMT_CTRL_EXT    3
`define FMT_CTRL_FRZ    4
`define FMT_CTRL_TWO    5
`define FMT_CTRL_ONE    6
`define FMT_CTRL_WE1D   8
`define FMT_CTRL_BLKD   10
`define FMT_CTRL_WE2D   12

// Start value in the low half, stop value in the high half
`define FMT_LO_POS      0
`define FMT_HI_POS      16
`define FMT_STAT_VDISP  16

// ****************************************
// Reset values
// ****************************************
`define FMT_RST_ALINE   32'h0000_0300
`define FMT_RST_DLINE   32'h0000_0400

// ****************************************
// Timing
// ****************************************
`define FMT_CLK_NS      10
`define FMT_WRST_NS     32000
`define FMT_WRST_CYC    ((`FMT_WRST_NS) / (`FMT_CLK_NS))

`endif

// file: rtl/fmt_pkg.sv
// Types shared by the field memory timing block and its bench
package fmt_pkg;

   // ****************************************
   // Acquisition side outputs
   // ****************************************
   typedef struct packed {
      logic mem1SerialWriteClock;
      logic acqHalfClock;
      logic acqHorizRef;
      logic videoClampPulse;
      logic mem1WriteEnable;
      logic vertSampleFirst;
      logic vertSampleSecond;
      logic mem1WriteReset;
   } fmt_acq_out_s;

   // ****************************************
   // Display side outputs
   // ****************************************
   typedef struct packed {
      logic serialReadClock;
      logic displayHorizRef;
      logic dispVertStepPulses;
      logic displayBlanking;
      logic mem2WriteEnable;
   } fmt_disp_out_s;

   // ****************************************
   // Whole state of the block
   // ****************************************
   typedef struct packed {
      logic [11:0][31:0] cfg;
      logic              dphWr;
      logic [5:0]        dphIdx;
      logic [31:0]       rdata;
      logic              hreadyOut;
      logic              acqPrev;
      logic              extPrev;
      logic              dispPrev;
      logic [13:0]       hCnt;
      logic [9:0]        vLine;
      logic              hWin1;
      logic              vWin1;
      logic              vsSmp;
      logic [2:0]        we1Sh;
      logic [9:0]        fieldLen;
      logic [11:0]       wrstCnt;
      logic              ieBase;
      logic [13:0]       dCnt;
      logic [9:0]        vDisp;
      logic              hWin2;
      logic              vWin2;
      logic [2:0]        blnkSh;
      logic [2:0]        we2Sh;
      fmt_acq_out_s      acq;
      fmt_disp_out_s     disp;
   } fmt_state_s;

endpackage : fmt_pkg

// file: rtl/fmt_timing_ctrl.sv
// Acquisition and display control timing of a field memory controller, with AHB-Lite registers
//
// Implementation choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "fmt_defines.svh"

module fmt_timing_ctrl #(
   parameter int CW = 14
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   // AHB-Lite slave
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic                        hreadyout,
   output logic                        hresp,
   output logic [31:0]                 hrdata,
   // Acquisition side pins
   input  wire logic                   acqClockIn,
   input  wire logic                   extHorizReset,
   input  wire logic                   acqVertSync,
   input  wire logic                   strobe,
   output fmt_pkg::fmt_acq_out_s       acqOut,
   output logic                        mem1InputEnable,
   // Display side pins
   input  wire logic                   displayClockIn,
   input  wire logic                   deflectionClockIn,
   output fmt_pkg::fmt_disp_out_s      dispOut
);
   import fmt_pkg::*;

   // ****************************************
   // Helper functions
   // ****************************************
   // Horizontal edges are counts after the line reset,
   // a programmed value scaled by a power of two plus two.
   // Windows run from rise to fall and may wrap the line end.

   // Edge position: programmed value times 2^sh, plus two
   function automatic logic [CW-1:0] edgeAt(input logic [8:0] n, input logic [2:0] sh);
      logic [CW-1:0] v;
      v = CW'({5'h00, n} << sh);
      return v + CW'(2);
   endfunction : edgeAt

   // Window open from rise up to fall, wrapping over the line end
   function automatic logic inWin(input logic [CW-1:0] c, input logic [CW-1:0] r,
                                  input logic [CW-1:0] f);
      if (r <= f) begin
         return (c >= r) && (c < f);
      end
      return (c >= r) || (c < f);
   endfunction : inWin

   // Delay tap: 0 gives the current value, 1..3 older ones
   function automatic logic dsel(input logic cur, input logic [2:0] sh, input logic [1:0] d);
      case (d)
         2'd0:    return cur;
         2'd1:    return sh[0];
         2'd2:    return sh[1];
         default: return sh[2];
      endcase
   endfunction : dsel

   // Vertical line window from a start/stop word
   function automatic logic lineWin(input logic [9:0] l, input logic [31:0] w);
      return (l >= w[`FMT_LO_POS +: 9]) && (l < w[`FMT_HI_POS +: 9]);
   endfunction : lineWin

   // ****************************************
   // State and decoded controls
   // ****************************************
   // One packed struct holds every register of the block.
   fmt_state_s s_q;                        // Registered state
   fmt_state_s s_d;                        // Next state

   localparam int IX_CTRL   = `FMT_OFF_CTRL / 4;
   localparam int IX_CLAMP  = `FMT_OFF_CLAMP / 4;
   localparam int IX_HWIN1  = `FMT_OFF_HWIN1 / 4;
   localparam int IX_VSAMP  = `FMT_OFF_VSAMP / 4;
   localparam int IX_VWIN1  = `FMT_OFF_VWIN1 / 4;
   localparam int IX_ALINE  = `FMT_OFF_ALINE / 4;
   localparam int IX_STEP01 = `FMT_OFF_STEP01 / 4;
   localparam int IX_STEP23 = `FMT_OFF_STEP23 / 4;
   localparam int IX_BLANK  = `FMT_OFF_BLANK / 4;
   localparam int IX_HWIN2  = `FMT_OFF_HWIN2 / 4;
   localparam int IX_VWIN2  = `FMT_OFF_VWIN2 / 4;
   localparam int IX_DLINE  = `FMT_OFF_DLINE / 4;
   localparam int IX_STATUS = `FMT_OFF_STATUS / 4;

   logic [31:0] ctrl;                      // Control word
   logic [1:0]  freqSel;                   // Acquisition frequency select
   logic        acqRateDouble;             // Doubled acquisition rate
   logic        externalAcqClockSel;       // External source mode
   logic        freezeMem1Writes;          // Still picture
   logic        twoClock;                  // Two-clock system
   logic        singleClock;               // Single-clock system
   logic [2:0]  shClamp;                   // Shift for clamp and sampling edges
   logic [2:0]  shWin;                     // Shift for write window edges

   always_comb begin
      ctrl                = s_q.cfg[IX_CTRL];
      freqSel             = ctrl[`FMT_CTRL_FSEL +: 2];
      acqRateDouble       = ctrl[`FMT_CTRL_DBL];
      externalAcqClockSel = ctrl[`FMT_CTRL_EXT];
      freezeMem1Writes    = ctrl[`FMT_CTRL_FRZ];
      twoClock            = ctrl[`FMT_CTRL_TWO];
      singleClock         = ctrl[`FMT_CTRL_ONE];
      // 18 MHz or external source use the wider steps; doubling adds one more
      shClamp = 3'd2 + 3'((freqSel == 2'b11) | externalAcqClockSel)
              + 3'(acqRateDouble);
      shWin   = 3'd1 + 3'((freqSel == 2'b11) | externalAcqClockSel)
              + 3'(acqRateDouble);
   end

   // ****************************************
   // Next-state logic
   // ****************************************
   logic            ap;                    // Address phase accepted
   logic [5:0]      aIdx;                  // Register index of address phase
   logic            acqEdge;               // Rising acquisition clock
   logic            dispEdge;              // Rising selected display clock
   logic            selClk;                // Selected display clock level
   logic            lineWrap;              // Acquisition line end
   logic            vref;                  // Vertical sync rise seen at sampling
   logic            smp1;                  // First sampling pulse position
   logic            smp2;                  // Second sampling pulse position
   logic            hw;                    // New horizontal write window 1
   logic            hw2;                   // New horizontal window 2
   logic            step;                  // Any display step position
   logic [CW-1:0]   hNext;                 // Next acquisition count
   logic [CW-1:0]   dNext;                 // Next display count
   logic [CW-1:0]   aLen;                  // Acquisition line length
   logic [CW-1:0]   dLen;                  // Display line length
   logic [3:0][8:0] stepPos;               // Four step positions
   logic            blk;                   // Undelayed blanking window

   always_comb begin
      s_d      = s_q;
      vref     = 1'b0;
      lineWrap = 1'b0;
      smp1     = 1'b0;
      smp2     = 1'b0;
      hw       = s_q.hWin1;
      hw2      = s_q.hWin2;
      step     = 1'b0;
      blk      = 1'b0;
      hNext    = s_q.hCnt;
      dNext    = s_q.dCnt;
      aLen     = s_q.cfg[IX_ALINE][CW-1:0];
      dLen     = s_q.cfg[IX_DLINE][CW-1:0];
      stepPos  = {s_q.cfg[IX_STEP23][`FMT_HI_POS +: 9], s_q.cfg[IX_STEP23][`FMT_LO_POS +: 9],
                  s_q.cfg[IX_STEP01][`FMT_HI_POS +: 9], s_q.cfg[IX_STEP01][`FMT_LO_POS +: 9]};

      // Zero wait states: hreadyout stays high, so a read must
      // be fetched when its address phase is taken.
      // Bus: word writes land in the data phase, reads are fetched in the address phase
      s_d.hreadyOut = 1'b1;
      if (s_q.dphWr) begin
         s_d.cfg[s_q.dphIdx[3:0]] = hwdata;
      end
      ap   = hsel & htrans[1] & hready;
      aIdx = haddr[7:2];
      s_d.dphWr = ap & hwrite & (aIdx < 6'(`FMT_NUM_CFG)) & (hsize == 3'b010);
      s_d.dphIdx = aIdx;
      if (ap && !hwrite) begin
         if (s_q.dphWr && s_q.dphIdx == aIdx) begin
            // Forward a write still in its data phase
            s_d.rdata = hwdata;
         end else if (aIdx < 6'(`FMT_NUM_CFG)) begin
            s_d.rdata = s_q.cfg[aIdx[3:0]];
         end else if (aIdx == 6'(IX_STATUS)) begin
            s_d.rdata = 32'h0;
            s_d.rdata[9:0] = s_q.fieldLen;
            s_d.rdata[`FMT_STAT_VDISP +: 10] = s_q.vDisp;
         end else begin
            // Unmapped: zero
            s_d.rdata = 32'h0;
         end
      end

      // Acquisition clock buffering and division
      acqEdge = acqClockIn & ~s_q.acqPrev;
      s_d.acqPrev = acqClockIn;
      s_d.acq.mem1SerialWriteClock = acqClockIn;
      if (acqEdge) begin
         s_d.acq.acqHalfClock = ~s_q.acq.acqHalfClock;
      end

      // The acquisition clock is sampled as data, so every step
      // below happens on the one system clock after its rise.
      // In external mode only the outside reference ends a line.
      // Acquisition horizontal timing, one step per acquisition clock
      if (acqEdge) begin
         s_d.extPrev = extHorizReset;
         if (externalAcqClockSel) begin
            lineWrap = extHorizReset & ~s_q.extPrev;
         end else begin
            lineWrap = (s_q.hCnt >= aLen - CW'(1));
         end
         hNext = lineWrap ? '0 : s_q.hCnt + CW'(1);
         s_d.hCnt = hNext;
         // Reference rises with the counter reset, high for half the programmed line length
         s_d.acq.acqHorizRef = (hNext < (aLen >> 1));
         s_d.acq.videoClampPulse = inWin(hNext,
            edgeAt(s_q.cfg[IX_CLAMP][`FMT_LO_POS +: 9], shClamp),
            edgeAt(s_q.cfg[IX_CLAMP][`FMT_HI_POS +: 9], shClamp));
         hw = inWin(hNext,
            edgeAt(s_q.cfg[IX_HWIN1][`FMT_LO_POS +: 9], shWin),
            edgeAt(s_q.cfg[IX_HWIN1][`FMT_HI_POS +: 9], shWin));
         s_d.hWin1 = hw;
         // Vertical window follows the line count only at the horizontal window start
         if (hw && !s_q.hWin1) begin
            s_d.vWin1 = lineWin(s_q.vLine, s_q.cfg[IX_VWIN1]);
         end
         // Two sampling pulses of the vertical sync per line
         smp1 = (hNext == edgeAt(s_q.cfg[IX_VSAMP][`FMT_LO_POS +: 9], shClamp));
         smp2 = (hNext == edgeAt(s_q.cfg[IX_VSAMP][`FMT_HI_POS +: 9], shClamp));
         s_d.acq.vertSampleFirst  = smp1;
         s_d.acq.vertSampleSecond = smp2;
         if (smp1 || smp2) begin
            s_d.vsSmp = acqVertSync;
            vref = acqVertSync & ~s_q.vsSmp;
         end
         if (lineWrap) begin
            s_d.vLine = s_q.vLine + 10'd1;
         end
         if (vref) begin
            // New field: restart lines, close a window whose stop line never came
            s_d.fieldLen = s_q.vLine;
            s_d.vLine = 10'd0;
            s_d.vWin1 = 1'b0;
         end
         // Delay line holds the composite of the last three steps
         s_d.we1Sh = {s_q.we1Sh[1:0], hw & s_d.vWin1};
         s_d.acq.mem1WriteEnable = dsel(hw & s_d.vWin1, s_q.we1Sh,
                                        ctrl[`FMT_CTRL_WE1D +: 2]);
      end

      // A fixed count keeps the width independent of the
      // acquisition rate in use.
      // Write pointer reset pulse, timed in system clocks from the field start
      if (vref) begin
         s_d.wrstCnt = 12'(`FMT_WRST_CYC);
      end else if (s_q.wrstCnt != 12'd0) begin
         s_d.wrstCnt = s_q.wrstCnt - 12'd1;
      end
      s_d.acq.mem1WriteReset = (s_d.wrstCnt != 12'd0);

      // Still picture blocks input enable; strobe is merged after the flop
      s_d.ieBase = ~freezeMem1Writes;

      // Single clock wins over two clock; with neither set the
      // separate display clock input is used.
      // Display clock selection and buffering
      if (singleClock) begin
         selClk = acqClockIn;
      end else if (twoClock) begin
         selClk = deflectionClockIn;
      end else begin
         selClk = displayClockIn;
      end
      s_d.disp.serialReadClock = selClk;
      dispEdge = selClk & ~s_q.dispPrev;
      s_d.dispPrev = selClk;

      // Display edges always use the 2N+2 and 4N+2 equations;
      // every step position advances the display line count.
      // Display horizontal timing
      if (dispEdge) begin
         dNext = (s_q.dCnt >= dLen - CW'(1)) ? '0 : s_q.dCnt + CW'(1);
         s_d.dCnt = dNext;
         s_d.disp.displayHorizRef = (dNext < (dLen >> 1));
         for (int i = 0; i < 4; i++) begin
            step = step | (dNext == edgeAt(stepPos[i], 3'd2));
         end
         s_d.disp.dispVertStepPulses = step;
         if (step) begin
            s_d.vDisp = s_q.vDisp + 10'd1;
         end
         hw2 = inWin(dNext,
            edgeAt(s_q.cfg[IX_HWIN2][`FMT_LO_POS +: 9], 3'd1),
            edgeAt(s_q.cfg[IX_HWIN2][`FMT_HI_POS +: 9], 3'd1));
         s_d.hWin2 = hw2;
         if (hw2 && !s_q.hWin2) begin
            s_d.vWin2 = lineWin(s_q.vDisp, s_q.cfg[IX_VWIN2]);
         end
         // Taps hold older window values, never the delayed output
         blk = inWin(dNext,
            edgeAt(s_q.cfg[IX_BLANK][`FMT_LO_POS +: 9], 3'd1),
            edgeAt(s_q.cfg[IX_BLANK][`FMT_HI_POS +: 9], 3'd1));
         s_d.blnkSh = {s_q.blnkSh[1:0], blk};
         s_d.disp.displayBlanking = dsel(blk, s_q.blnkSh,
                                         ctrl[`FMT_CTRL_BLKD +: 2]);
         s_d.we2Sh = {s_q.we2Sh[1:0], hw2 & s_d.vWin2};
         s_d.disp.mem2WriteEnable = dsel(hw2 & s_d.vWin2,
                                         s_q.we2Sh, ctrl[`FMT_CTRL_WE2D +: 2]);
      end

      // Field start also restarts the display line count
      // The display vertical write window closes with it, as a new field begins
      if (vref) begin
         s_d.vDisp = 10'd0;
         s_d.vWin2 = 1'b0;
      end
   end

   // ****************************************
   // State register
   // ****************************************
   // Reset loads the line lengths so the counters run at once;
   // the bus is ready and input enable open from the start.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q                <= '0;
         s_q.cfg[IX_ALINE]  <= `FMT_RST_ALINE;
         s_q.cfg[IX_DLINE]  <= `FMT_RST_DLINE;
         s_q.hreadyOut      <= 1'b1;
         s_q.ieBase         <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // All outputs but hresp, which is tied low, come straight from the state register,
   // except the input enable, which the strobe must reach.
   assign hreadyout = s_q.hreadyOut;
   assign hresp     = 1'b0;
   assign hrdata    = s_q.rdata;
   assign acqOut    = s_q.acq;
   assign dispOut   = s_q.disp;
   // Strobe acts without sampling, so a freeze can be lifted at any instant
   assign mem1InputEnable = s_q.ieBase | strobe;

endmodule : fmt_timing_ctrl
`default_nettype wire

// file: verif/fmt_timing_ctrl_sva.sv
// Checker of the bus answer and the acquisition output timing
`timescale 1ns/1ps
`default_nettype none
module fmt_timing_ctrl_sva (
   // Clock and reset
   input wire logic                  clk,
   input wire logic                  rst_n,
   // Watched ports
   input wire logic                  hreadyout,
   input wire logic                  hresp,
   input wire logic                  acqClockIn,
   input wire logic                  strobe,
   input wire fmt_pkg::fmt_acq_out_s acqOut,
   input wire logic                  mem1InputEnable
);
   import fmt_pkg::*;
   logic [2:0]  acqHist_q; // Acq clock seen at the last three edges
   logic [12:0] wrstCnt_q; // Cycles the write reset has stood high
   // An acq step landed one or two edges ago
   wire logic   acqStep = (acqHist_q[0] & ~acqHist_q[1]) | (acqHist_q[1] & ~acqHist_q[2]);
   // *****
   // History and pulse counter
   // *****
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acqHist_q <= 3'h0;
         wrstCnt_q <= 13'h0;
      end else begin
         acqHist_q <= {acqHist_q[1:0], acqClockIn};
         wrstCnt_q <= acqOut.mem1WriteReset ? wrstCnt_q + 13'h1 : 13'h0;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Acq clock low then high at consecutive edges
   sequence s_acq_rise;
      !acqClockIn ##1 acqClockIn;
   endsequence
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("bus response not OKAY");
   a_ready_high: assert property (hreadyout == 1'b1)
      else $error("slave inserted a wait state");
   a_wclk_buffer: assert property (acqOut.mem1SerialWriteClock == acqHist_q[0])
      else $error("write clock does not follow acq clock");
   a_half_toggle: assert property (s_acq_rise |-> ##[1:2] $changed(acqOut.acqHalfClock))
      else $error("half clock missed an acq edge");
   a_half_quiet: assert property ($changed(acqOut.acqHalfClock) |-> acqStep)
      else $error("half clock moved without acq edge");
   a_strobe_pass: assert property (strobe |-> mem1InputEnable)
      else $error("strobe did not enable input");
   a_wrst_width: assert property ($fell(acqOut.mem1WriteReset) |-> wrstCnt_q == 13'hc80)
      else $error("write reset width wrong");
   a_wrst_bound: assert property (wrstCnt_q <= 13'hc80)
      else $error("write reset too long");
   a_clamp_step: assert property ($changed(acqOut.videoClampPulse) |-> acqStep)
      else $error("clamp edge off the acq clock");
   a_we1_step: assert property ($changed(acqOut.mem1WriteEnable) |-> acqStep)
      else $error("write enable edge off the acq clock");
   a_sample_step: assert property ($changed(acqOut.vertSampleFirst) |-> acqStep)
      else $error("sampling pulse off the acq clock");
endmodule : fmt_timing_ctrl_sva
bind fmt_timing_ctrl fmt_timing_ctrl_sva u_sva (.clk, .rst_n, .hreadyout, .hresp, .acqClockIn,
   .strobe, .acqOut, .mem1InputEnable);
`default_nettype wire

// file: verif/fmt_video_src.sv
// Far-side model: line-locked clocks, vertical sync and external line reference
`timescale 1ns/1ps
`default_nettype none
module fmt_video_src #(
   parameter int ACQ_HALF  = 3,    // Acq clock half period in clk
   parameter int FIELD_CLK = 9600, // Field period in clk
   parameter int SYNC_CLK  = 960,  // Vertical sync high time in clk
   parameter int EXT_CLK   = 480   // External line reference period in clk
) (
   // Clock
   input  wire logic clk,
   // Far-side clocks and syncs
   output logic      acqClockIn,
   output logic      extHorizReset,
   output logic      acqVertSync,
   output logic      displayClockIn,
   output logic      deflectionClockIn
);
   int unsigned tick = 0; // Free running count, PLLs never stop
   // Count clk edges
   always @(posedge clk) begin
      tick <= tick + 1;
   end
   assign acqClockIn        = (tick / ACQ_HALF) % 2 == 1;
   assign displayClockIn    = tick[1];
   assign deflectionClockIn = (tick / 5) % 2 == 1;
   assign acqVertSync       = (tick % FIELD_CLK) < SYNC_CLK;
   assign extHorizReset     = (tick % EXT_CLK) < EXT_CLK / 2;
endmodule : fmt_video_src
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench of the field memory timing block
`timescale 1ns/1ps
`default_nettype none
`include "fmt_defines.svh"
module tb_top;
   import fmt_pkg::*;
   logic          clk    = 1'b0;
   logic          rst_n  = 1'b0;
   logic          hsel   = 1'b0;
   logic          hwrite = 1'b0;
   logic          strobe = 1'b0;
   logic [1:0]    htrans = 2'h0;
   logic [2:0]    hsize  = 3'h2;
   logic [31:0]   haddr  = 32'h0;
   logic [31:0]   hwdata = 32'h0;
   logic [31:0]   rd;
   wire logic     hreadyout, hresp, mem1InputEnable, acqClockIn, extHorizReset;
   wire logic     acqVertSync, displayClockIn, deflectionClockIn;
   wire logic [31:0] hrdata;
   fmt_acq_out_s  acqOut;
   fmt_disp_out_s dispOut;
   int            miscompares = 0;
   int            cmpCount    = 0;
   int            w;
   logic          p;
   // Width table: control word, watched output, expected high time in clk
   logic [31:0]   ctl[13] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h4, 32'h300, 32'h0, 32'h0, 32'h0, 32'hc00, 32'h3000,
                             32'h0, 32'h0};
   int            sel[13] = '{0, 0, 0, 0, 0, 2, 1, 3, 4, 5, 6, 7, 8};
   logic [31:0]   exp[13] = '{32'd96, 32'd96, 32'd96, 32'd192, 32'd192, 32'd84, 32'd240, 32'd100, 32'd3200,
                             32'd56, 32'd56, 32'd4, 32'd6};
   wire logic [2:0] clkSet = {acqClockIn, deflectionClockIn, displayClockIn};
   wire logic [8:0] watch  = {acqOut.vertSampleSecond, dispOut.dispVertStepPulses, dispOut.mem2WriteEnable,
                              dispOut.displayBlanking, acqOut.mem1WriteReset, dispOut.displayHorizRef,
                              acqOut.mem1WriteEnable, acqOut.acqHorizRef, acqOut.videoClampPulse};
   fmt_video_src u_src (.clk, .acqClockIn, .extHorizReset, .acqVertSync, .displayClockIn, .deflectionClockIn);
   fmt_timing_ctrl u_dut (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
      .hreadyout, .hresp, .hrdata, .acqClockIn, .extHorizReset, .acqVertSync, .strobe, .acqOut,
      .mem1InputEnable, .displayClockIn, .deflectionClockIn, .dispOut);
   // 100 MHz clock
   initial begin
      forever #5 clk = ~clk;
   end
   // One AHB-Lite single word transfer, read data left in rd
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      cmpCount++;
      if (got !== want) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask : chk
   // High time of the next pulse on a watched output, bounded
   task automatic width(input int s, output int n);
      int t;
      t = 0;
      n = 0;
      // Let a pulse under way or cut by the new setting pass first
      while (watch[s] !== 1'b1 && t < 30000) begin @(negedge clk); t++; end
      while (watch[s] !== 1'b0 && t < 30000) begin @(negedge clk); t++; end
      while (watch[s] !== 1'b1 && t < 30000) begin @(negedge clk); t++; end
      while (watch[s] === 1'b1 && n < 20000) begin @(negedge clk); n++; end
   endtask : width
   // Counts, verdict and end of run
   task automatic wrap_up;
      $display("COUNTS compares=%0d mismatches=%0d", cmpCount, miscompares);
      if (miscompares == 0 && cmpCount > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   // Hang guard
   initial begin
      #900000;
      miscompares++;
      wrap_up();
   end
   // Test sequence
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, `FMT_OFF_CTRL, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, `FMT_OFF_ALINE, 32'h0);
      chk(rd, 32'h300);
      bus(1'b0, `FMT_OFF_DLINE, 32'h0);
      chk(rd, 32'h400);
      bus(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, `FMT_OFF_STATUS, 32'hffff_ffff);
      bus(1'b0, `FMT_OFF_STATUS, 32'h0);
      chk({22'h0, rd[9:0]}, 32'h0);
      $display("END registers");
      for (int m = 0; m < 3; m++) begin
         bus(1'b1, `FMT_OFF_CTRL, (m == 0) ? 32'h0 : (32'h10 << m));
         repeat (3) @(negedge clk);
         p = clkSet[m];
         repeat (8) begin
            @(negedge clk);
            chk(dispOut.serialReadClock, p);
            p = clkSet[m];
         end
      end
      $display("END clock select");
      bus(1'b1, `FMT_OFF_CTRL, 32'h10);
      repeat (2) @(negedge clk);
      chk(mem1InputEnable, 1'b0);
      @(posedge clk) strobe <= 1'b1;
      @(negedge clk);
      chk(mem1InputEnable, 1'b1);
      @(posedge clk) strobe <= 1'b0;
      bus(1'b1, `FMT_OFF_CTRL, 32'h0);
      repeat (2) @(negedge clk);
      chk(mem1InputEnable, 1'b1);
      $display("END still picture");
      bus(1'b1, `FMT_OFF_ALINE, 32'h50);
      bus(1'b1, `FMT_OFF_DLINE, 32'h32);
      bus(1'b1, `FMT_OFF_CLAMP, 32'h0006_0002);
      bus(1'b1, `FMT_OFF_HWIN1, 32'h000a_0003);
      bus(1'b1, `FMT_OFF_VSAMP, 32'h0005_0001);
      bus(1'b1, `FMT_OFF_VWIN1, 32'h0008_0002);
      bus(1'b1, `FMT_OFF_BLANK, 32'h000a_0003);
      bus(1'b1, `FMT_OFF_HWIN2, 32'h000a_0003);
      bus(1'b1, `FMT_OFF_VWIN2, 32'h0008_0002);
      bus(1'b1, `FMT_OFF_STEP01, 32'h0000_0001);
      bus(1'b0, `FMT_OFF_VWIN1, 32'h0);
      chk(rd, 32'h0008_0002);
      for (int i = 0; i < 13; i++) begin
         bus(1'b1, `FMT_OFF_CTRL, ctl[i]);
         width(sel[i], w);
         chk(w, exp[i]);
      end
      bus(1'b0, `FMT_OFF_STATUS, 32'h0);
      chk({22'h0, rd[9:0]}, 32'h14);
      $display("END pulse widths");
      bus(1'b1, `FMT_OFF_ALINE, 32'h3e8);
      bus(1'b1, `FMT_OFF_CTRL, 32'h8);
      width(0, w);
      chk(w, 32'd192);
      $display("END external source");
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
